// >>> rtl/fault_sampler.sv
// Synchronises the overload pin and counts consecutive low samples.
`timescale 1ns/1ps
`default_nettype none
module fault_sampler #(
    parameter int count_width = 4
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   clk_en,
    input  wire logic                   fault_n_pin,
    input  wire logic [count_width-1:0] sample_count,
    output logic                        fault_low,
    output logic                        detect
);
    localparam int div_width = $clog2(motor_protect_pkg::sample_div);

    initial
    begin
        if (count_width < 1 || motor_protect_pkg::sample_div < 2)
            $error("fault_sampler: unsupported parameters");
    end

    logic                   meta_reg;
    logic                   sync_reg;
    logic [div_width-1:0]   div_reg;
    logic [count_width-1:0] lows_reg;
    logic [count_width-1:0] need;
    logic                   tick;

    // Two flip-flops bring the pin into the clock domain.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
        end
        else if (clk_en)
        begin
            meta_reg <= fault_n_pin;
            sync_reg <= meta_reg;
        end
    end

    // Prescaler giving one sample strobe every four clocks.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_reg <= '0;
        else if (clk_en)
            div_reg <= tick ? '0 : div_reg + 1'b1;
    end

    assign tick = (div_reg == div_width'(motor_protect_pkg::sample_div - 1));
    // Settings zero and one both ask for a single sample.
    assign need = (sample_count == '0) ? count_width'(1) : sample_count;
    assign fault_low = !sync_reg;

    // Consecutive low samples; a high sample restarts the run.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lows_reg <= '0;
            detect   <= 1'b0;
        end
        else if (clk_en)
        begin
            detect <= 1'b0;
            if (tick)
            begin
                if (!sync_reg)
                begin
                    // Compared against need - 1 so a count of 15 cannot wrap.
                    if (lows_reg >= need - 1'b1)
                    begin
                        detect   <= 1'b1;
                        lows_reg <= need;
                    end
                    else
                        lows_reg <= lows_reg + 1'b1;
                end
                else
                    lows_reg <= '0;
            end
        end
    end
endmodule : fault_sampler
`default_nettype wire

// >>> rtl/motor_fault_protection_regs.sv
// APB register block for emergency-stop and overload protection.
//
// Contract
// - Enable clears only after 5a then a5.
// - Unlock and overload control reset to zero.
// - Software return releases overload at once.
// - PWM-sync and timer-sync release enables.
// - Software return outranks synchronised return.
// - Selector picks none, all, PWM, upper/lower.
// - Upper/lower mode follows majority of phases on.
// - n consecutive low samples, every 4 clocks.
// - Status bit shows emergency protective state.
// - Writing one to return releases emergency state.
// - Return ignored while emergency input is low.
// - Enable bit turns emergency circuit on/off.
// - Emergency circuit enabled out of reset.
`timescale 1ns/1ps
`default_nettype none
module motor_fault_protection_regs #(
    parameter int phases = 3
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  clk_en,
    input  wire logic [15:0]           paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  emergency_stop_input_n,
    input  wire logic                  overload_fault_n,
    input  wire logic                  pwm_sync,
    input  wire logic                  timer_sync,
    input  wire logic [2*phases-1:0]   phase_on,
    input  wire logic [2*phases-1:0]   pwm_phases,
    output logic [2*phases-1:0]        phase_disable,
    output logic [2*phases-1:0]        phase_force_on,
    output logic                       counter_stop,
    output logic                       estop_active_flag,
    output logic                       irq
);
    initial
    begin
        if (phases < 2)
            $error("motor_fault_protection_regs: need two or more phases");
    end

    logic [13:0]  idx;
    logic         hit_ol, hit_key, hit_ec, hit_st, hit_mk, mapped;
    logic         wr, rd_setup;
    logic         wr_ol, wr_key, wr_ec, wr_st, wr_mk;
    logic [7:0]   wbyte;
    logic         unlocked;
    logic         fault_low, detect;
    logic         est_meta_reg, est_sync_reg;
    logic         estop_low;
    logic         estop_enable_reg;
    logic [3:0]   sample_count_reg;
    logic         estop_active_reg;
    logic         return_on_pwm_sync_reg, return_on_timer_sync_reg;
    logic [1:0]   phase_disable_select_reg;
    logic         counter_freeze_reg, overload_detect_enable_reg;
    logic         overload_active_reg;
    logic [2*phases-1:0] snapshot_reg;
    logic         ol_set, ol_release, sw_return, sync_return;
    logic         es_set, es_release;
    logic [1:0]   irq_status_reg, irq_mask_reg, irq_event;
    logic [7:0]   rbyte;
    logic         upper_major;

    // Address decode: only word-aligned accesses hit a register.
    assign idx     = paddr[15:2];
    assign hit_ol  = paddr[1:0] == 2'h0 &&
                     idx == motor_protect_pkg::overload_control_idx;
    assign hit_key = paddr[1:0] == 2'h0 &&
                     idx == motor_protect_pkg::protection_unlock_key_idx;
    assign hit_ec  = paddr[1:0] == 2'h0 &&
                     idx == motor_protect_pkg::emergency_control_idx;
    assign hit_st  = paddr[1:0] == 2'h0 &&
                     idx == motor_protect_pkg::irq_status_idx;
    assign hit_mk  = paddr[1:0] == 2'h0 &&
                     idx == motor_protect_pkg::irq_mask_idx;
    assign mapped  = hit_ol | hit_key | hit_ec | hit_st | hit_mk;

    // Zero wait states while running; a frozen block stalls the bus.
    assign pready   = clk_en;
    assign pslverr  = psel & penable & !mapped;
    assign wr       = clk_en & psel & penable & pwrite & pstrb[0] & mapped;
    assign rd_setup = clk_en & psel & !penable & !pwrite;
    assign wbyte    = pwdata[7:0];
    assign wr_ol    = wr & hit_ol;
    assign wr_key   = wr & hit_key;
    assign wr_ec    = wr & hit_ec;
    assign wr_st    = wr & hit_st;
    assign wr_mk    = wr & hit_mk;

    // Unlock key sequence, used up by the next emergency control write.
    unlock_key_seq u_key (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .key_write (wr_key),
        .key_data  (wbyte),
        .consume   (wr_ec),
        .unlocked  (unlocked)
    );

    // Overload pin synchroniser and consecutive-sample detector.
    fault_sampler #(
        .count_width (4)
    ) u_sampler (
        .pclk         (pclk),
        .presetn      (presetn),
        .clk_en       (clk_en),
        .fault_n_pin  (overload_fault_n),
        .sample_count (sample_count_reg),
        .fault_low    (fault_low),
        .detect       (detect)
    );

    // Emergency-stop pin synchroniser.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            est_meta_reg <= 1'b1;
            est_sync_reg <= 1'b1;
        end
        else if (clk_en)
        begin
            est_meta_reg <= emergency_stop_input_n;
            est_sync_reg <= est_meta_reg;
        end
    end

    assign estop_low = !est_sync_reg;

    // Emergency control: enable starts set, clears only when unlocked.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            estop_enable_reg <= motor_protect_pkg::estop_enable_rst;
            sample_count_reg <= motor_protect_pkg::sample_count_rst;
        end
        else if (wr_ec)
        begin
            sample_count_reg <=
                wbyte[motor_protect_pkg::fault_sample_count_lsb +: 4];
            if (wbyte[motor_protect_pkg::estop_circuit_enable_bit])
                estop_enable_reg <= 1'b1;
            else if (unlocked)
                estop_enable_reg <= 1'b0;
        end
    end

    // Emergency state: return needs a one and a high input.
    assign es_set     = estop_enable_reg & estop_low;
    assign es_release = wr_ec & wbyte[motor_protect_pkg::estop_return_bit] &
                        !estop_low;

    // An arriving stop outranks a return in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            estop_active_reg <= 1'b0;
        else if (clk_en)
        begin
            if (es_set)
                estop_active_reg <= 1'b1;
            else if (es_release)
                estop_active_reg <= 1'b0;
        end
    end

    // Overload control fields; all start at zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {return_on_pwm_sync_reg, return_on_timer_sync_reg} <= 2'h0;
            phase_disable_select_reg   <= motor_protect_pkg::mode_none;
            counter_freeze_reg         <= 1'b0;
            overload_detect_enable_reg <= 1'b0;
        end
        else if (wr_ol)
        begin
            return_on_pwm_sync_reg <=
                wbyte[motor_protect_pkg::return_on_pwm_sync_bit];
            return_on_timer_sync_reg <=
                wbyte[motor_protect_pkg::return_on_timer_sync_bit];
            phase_disable_select_reg <=
                wbyte[motor_protect_pkg::phase_disable_select_lsb +: 2];
            counter_freeze_reg <=
                wbyte[motor_protect_pkg::counter_freeze_on_fault_bit];
            overload_detect_enable_reg <=
                wbyte[motor_protect_pkg::overload_detect_enable_bit];
        end
    end

    // Release sources; software return wins over either sync.
    assign sw_return   = wr_ol & wbyte[motor_protect_pkg::software_return_bit];
    assign sync_return = !fault_low &
                         ((return_on_pwm_sync_reg & pwm_sync) |
                          (return_on_timer_sync_reg & timer_sync));
    assign ol_release  = sw_return | sync_return;
    assign ol_set      = overload_detect_enable_reg & detect;

    // Overload state and a snapshot of the phases on at its onset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overload_active_reg <= 1'b0;
            snapshot_reg        <= '0;
        end
        else if (clk_en)
        begin
            if (ol_set)
            begin
                overload_active_reg <= 1'b1;
                if (!overload_active_reg)
                    snapshot_reg <= phase_on;
            end
            else if (ol_release)
                overload_active_reg <= 1'b0;
        end
    end

    // Upper phases are the low half; majority means two or more on.
    always_comb
    begin
        int ups;
        ups = 0;
        for (int i = 0; i < phases; i++)
            ups = ups + int'(snapshot_reg[i]);
        upper_major = ups >= 2;
    end

    // Phase gating while overloaded, per the selector.
    always_comb
    begin
        phase_disable  = '0;
        phase_force_on = '0;
        if (overload_active_reg)
        begin
            case (phase_disable_select_reg)
                motor_protect_pkg::mode_none:
                    phase_disable = '0;
                motor_protect_pkg::mode_all:
                    phase_disable = '1;
                motor_protect_pkg::mode_pwm:
                    phase_disable = pwm_phases;
                motor_protect_pkg::mode_up_down:
                begin
                    phase_force_on = upper_major ?
                        {{phases{1'b0}}, {phases{1'b1}}} :
                        {{phases{1'b1}}, {phases{1'b0}}};
                    phase_disable  = ~phase_force_on;
                end
                default:
                    phase_disable = '0;
            endcase
        end
    end

    assign counter_stop      = overload_active_reg & counter_freeze_reg;
    assign estop_active_flag = estop_active_reg;

    // Entry into either protective state is a sticky interrupt event.
    assign irq_event[motor_protect_pkg::irq_estop_bit]    =
        es_set & !estop_active_reg;
    assign irq_event[motor_protect_pkg::irq_overload_bit] =
        ol_set & !overload_active_reg;

    // Status bits clear on a written one, but a new event wins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status_reg <= 2'h0;
        else if (clk_en)
            irq_status_reg <= irq_event |
                (irq_status_reg & ~(wr_st ? wbyte[1:0] : 2'h0));
    end

    // Interrupt mask.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask_reg <= motor_protect_pkg::irq_mask_rst;
        else if (wr_mk)
            irq_mask_reg <= wbyte[1:0];
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // Read mux; the emergency return bit and the key register read as zero; overload bit 7 reads the active flag.
    always_comb
    begin
        rbyte = 8'h00;
        if (hit_ol)
            rbyte = {overload_active_reg, return_on_pwm_sync_reg,
                     return_on_timer_sync_reg, overload_active_reg,
                     phase_disable_select_reg, counter_freeze_reg,
                     overload_detect_enable_reg};
        else if (hit_ec)
            rbyte = {sample_count_reg, 1'b0, estop_active_reg, 1'b0,
                     estop_enable_reg};
        else if (hit_st)
            rbyte = {6'h00, irq_status_reg};
        else if (hit_mk)
            rbyte = {6'h00, irq_mask_reg};
    end

    // Read data is captured in the setup cycle and held for the access.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_setup)
            prdata <= {24'h00_0000, rbyte};
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_key_read;
        rd_setup && hit_key;
    endsequence

    property p_key_reads_zero;
        s_key_read |=> prdata == 32'h0000_0000;
    endproperty
    a_key_reads_zero: assert property (p_key_reads_zero)
        else $error("unlock key register read nonzero");

    property p_enable_clear_needs_key;
        $fell(estop_enable_reg) |-> $past(unlocked) && $past(wr_ec);
    endproperty
    a_enable_clear_needs_key: assert property (p_enable_clear_needs_key)
        else $error("emergency enable cleared without unlock key");

    property p_sw_return;
        sw_return && !ol_set |=> !overload_active_reg;
    endproperty
    a_sw_return: assert property (p_sw_return)
        else $error("software return did not release overload");

    property p_sync_disabled;
        overload_active_reg && !sw_return && !return_on_pwm_sync_reg &&
        !return_on_timer_sync_reg |=> overload_active_reg;
    endproperty
    a_sync_disabled: assert property (p_sync_disabled)
        else $error("overload released by a disabled source");

    property p_mode_all;
        overload_active_reg && phase_disable_select_reg ==
            motor_protect_pkg::mode_all |-> &phase_disable;
    endproperty
    a_mode_all: assert property (p_mode_all)
        else $error("all-phase mode left a phase enabled");

    property p_up_down;
        overload_active_reg && phase_disable_select_reg ==
            motor_protect_pkg::mode_up_down && upper_major
        |-> phase_force_on[0] && phase_disable[phases];
    endproperty
    a_up_down: assert property (p_up_down)
        else $error("upper majority did not force upper phases");

    sequence s_estop_seen;
        estop_enable_reg && estop_low && clk_en;
    endsequence

    property p_estop_set;
        s_estop_seen |=> estop_active_flag;
    endproperty
    a_estop_set: assert property (p_estop_set)
        else $error("emergency state not entered");

    property p_return_blocked;
        estop_active_reg && estop_low && wr_ec |=> estop_active_reg;
    endproperty
    a_return_blocked: assert property (p_return_blocked)
        else $error("emergency return taken while input low");

    property p_return_taken;
        estop_active_reg && !es_set && es_release |=> !estop_active_reg;
    endproperty
    a_return_taken: assert property (p_return_taken)
        else $error("emergency return ignored");

    property p_detect_gate;
        !overload_detect_enable_reg && !overload_active_reg
        |=> !overload_active_reg;
    endproperty
    a_detect_gate: assert property (p_detect_gate)
        else $error("overload raised while detection disabled");

endmodule : motor_fault_protection_regs
`default_nettype wire

// >>> rtl/motor_protect_pkg.sv
// Shared constants for the motor-drive protection register block.
package motor_protect_pkg;

    // Register indexes as printed; the APB byte address is four times these.
    localparam logic [13:0] overload_control_idx      = 14'h1fb1;
    localparam logic [13:0] protection_unlock_key_idx = 14'h1fbf;
    localparam logic [13:0] emergency_control_idx     = 14'h1fb0;
    localparam logic [13:0] irq_status_idx            = 14'h1fc0;
    localparam logic [13:0] irq_mask_idx              = 14'h1fc1;
    localparam int          addr_width                = 16;

    // Reset values of the software-visible registers.
    localparam logic [7:0] overload_control_rst  = 8'h00;
    localparam logic [7:0] unlock_key_rst        = 8'h00;
    localparam logic       estop_enable_rst      = 1'b1;
    localparam logic [3:0] sample_count_rst      = 4'h0;
    localparam logic [1:0] irq_mask_rst          = 2'h0;

    // Field positions of overload_control.
    localparam int software_return_bit         = 7;
    localparam int return_on_pwm_sync_bit      = 6;
    localparam int return_on_timer_sync_bit    = 5;
    localparam int overload_active_flag_bit    = 4;
    localparam int phase_disable_select_lsb    = 2;
    localparam int counter_freeze_on_fault_bit = 1;
    localparam int overload_detect_enable_bit  = 0;

    // Field positions of emergency_control.
    localparam int fault_sample_count_lsb = 4;
    localparam int estop_active_flag_bit  = 2;
    localparam int estop_return_bit       = 1;
    localparam int estop_circuit_enable_bit = 0;

    // Interrupt status and mask bit positions.
    localparam int irq_estop_bit    = 0;
    localparam int irq_overload_bit = 1;

    // Unlock key bytes, to be written in this order.
    localparam logic [7:0] key_first  = 8'h5a;
    localparam logic [7:0] key_second = 8'ha5;

    // Phase disable selector codes.
    localparam logic [1:0] mode_none     = 2'h0;
    localparam logic [1:0] mode_all      = 2'h1;
    localparam logic [1:0] mode_pwm      = 2'h2;
    localparam logic [1:0] mode_up_down  = 2'h3;

    // Fault sampling period: one sample every 200 ns at 50 ns per clock.
    localparam int clk_period_ns    = 50;
    localparam int sample_period_ns = 200;
    localparam int sample_div       = sample_period_ns / clk_period_ns;

    // Unlock sequence states, Gray coded along the usual path.
    typedef enum logic [1:0] {
        key_locked = 2'b00,
        key_half   = 2'b01,
        key_open   = 2'b11
    } key_state_type;

endpackage : motor_protect_pkg

// >>> rtl/unlock_key_seq.sv
// Two-byte unlock sequence that permits switching off the emergency stop.
`timescale 1ns/1ps
`default_nettype none
module unlock_key_seq (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clk_en,
    input  wire logic       key_write,
    input  wire logic [7:0] key_data,
    input  wire logic       consume,
    output logic            unlocked
);
    motor_protect_pkg::key_state_type state_reg;

    // A wrong byte drops back to locked; a control write uses up the key.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= motor_protect_pkg::key_locked;
        else if (clk_en)
        begin
            if (key_write)
            begin
                if (key_data == motor_protect_pkg::key_first)
                    state_reg <= motor_protect_pkg::key_half;
                else if (key_data == motor_protect_pkg::key_second &&
                         state_reg == motor_protect_pkg::key_half)
                    state_reg <= motor_protect_pkg::key_open;
                else
                    state_reg <= motor_protect_pkg::key_locked;
            end
            else if (consume)
                state_reg <= motor_protect_pkg::key_locked;
        end
    end

    // The key is valid only after both bytes arrived in order.
    always_comb
    begin
        case (state_reg)
            motor_protect_pkg::key_open: unlocked = 1'b1;
            default:                     unlocked = 1'b0;
        endcase
    end
endmodule : unlock_key_seq
`default_nettype wire

// >>> test/fault_pins.sv
// Model of the external emergency-stop and overload fault pins.
`timescale 1ns/1ps
`default_nettype none
module fault_pins (
    input  wire logic estop_req,
    input  wire logic ovl_req,
    output logic      estop_n,
    output logic      ovl_n
);
    // Pins have pull-ups, so a released pin reads high.
    assign estop_n = !estop_req;
    assign ovl_n   = !ovl_req;
endmodule : fault_pins
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the motor protection register block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        e_req = 0, o_req = 0, pwm_sync = 0, timer_sync = 0, ce = 1;
    logic        estop_n, ovl_n, pready, pslverr, counter_stop, irq, est, er;
    logic [15:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [5:0]  phase_on = 0, pwm_ph = 0, dis, fon;
    logic [7:0]  w;
    int          n_mismatch = 0, compares = 0, n;
    // The clock runs at 20 MHz.
    always #25 pclk = ~pclk;
    fault_pins u_pins (.estop_req(e_req), .ovl_req(o_req),
        .estop_n(estop_n), .ovl_n(ovl_n));
    motor_fault_protection_regs u_dut (.pclk(pclk), .presetn(presetn),
        .clk_en(ce), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .emergency_stop_input_n(estop_n),
        .overload_fault_n(ovl_n), .pwm_sync(pwm_sync),
        .timer_sync(timer_sync), .phase_on(phase_on), .pwm_phases(pwm_ph),
        .phase_disable(dis), .phase_force_on(fon),
        .counter_stop(counter_stop),
        .estop_active_flag(est), .irq(irq));
    // Compares a result and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            compares++;
            if (got !== exp)
            begin
                n_mismatch++;
                $display("mismatch at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask : chk
    // Plain whole-byte APB transfer; read data lands in rd.
    task automatic apb(input logic wr, input logic [13:0] i,
                       input logic [7:0] d);
        begin
            @(posedge pclk);
            paddr <= {i, 2'b00};
            pwrite <= wr;
            pwdata <= {24'h0, d};
            psel <= 1'b1;
            @(posedge pclk);
            penable <= 1'b1;
            do @(posedge pclk); while (pready !== 1'b1);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            #1;
        end
    endtask : apb
    // Waits some edges and lets their updates settle.
    task automatic wt(input int c);
        begin
            repeat (c) @(posedge pclk);
            #1;
        end
    endtask : wt
    // Expected disabled phases for a selector code.
    function automatic logic [5:0] exp_dis(input logic [1:0] md);
        case (md)
            2'h0: return 6'h00;
            2'h1: return 6'h3f;
            2'h2: return pwm_ph;
            default: return ($countones(phase_on[2:0]) >= 2) ? 6'h38 : 6'h07;
        endcase
    endfunction : exp_dis
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out;
        begin
            $display("mismatches %0d compares %0d", n_mismatch, compares);
            if (n_mismatch == 0 && compares > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask : close_out
    // Cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        close_out();
    end
    // Main test sequence.
    initial
    begin
        void'($urandom(59));
        phase_on <= $urandom;
        pwm_ph <= $urandom;
        n = 2 + $urandom % 14;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, motor_protect_pkg::overload_control_idx, 0);
        chk(rd, 0);
        apb(0, motor_protect_pkg::protection_unlock_key_idx, 0);
        chk(rd, 0);
        apb(0, motor_protect_pkg::emergency_control_idx, 0);
        chk(rd, 1);
        e_req <= 1'b1;
        wt(4);
        chk(est, 1);
        apb(1, motor_protect_pkg::emergency_control_idx, 8'h03);
        apb(0, motor_protect_pkg::emergency_control_idx, 0);
        chk(rd, 32'h05);
        e_req <= 1'b0;
        wt(4);
        apb(1, motor_protect_pkg::emergency_control_idx, 8'h03);
        apb(0, motor_protect_pkg::emergency_control_idx, 0);
        chk(rd, 1);
        apb(1, motor_protect_pkg::emergency_control_idx, 8'h00);
        apb(0, motor_protect_pkg::emergency_control_idx, 0);
        chk(rd, 1);
        apb(1, motor_protect_pkg::protection_unlock_key_idx, 8'h5a);
        apb(1, motor_protect_pkg::protection_unlock_key_idx, 8'ha5);
        apb(1, motor_protect_pkg::emergency_control_idx, {n[3:0], 4'h0});
        apb(0, motor_protect_pkg::emergency_control_idx, 0);
        chk(rd, {n[3:0], 4'h0});
        // Overload in each selector mode, released by each return source.
        for (int m = 0; m < 4; m++)
        begin
            apb(1, motor_protect_pkg::overload_control_idx, 8'h03 | m << 2);
            o_req <= 1'b1;
            wt(4 * n - 1);
            chk(counter_stop, 0);
            wt(5);
            chk(dis, exp_dis(m));
            chk(fon, m == 3 ? 6'h3f ^ exp_dis(m) : 6'h00);
            chk(counter_stop, 1);
            o_req <= 1'b0;
            wt(4);
            w = 8'h03 | m << 2 | (m == 1 ? 8'h40 : m == 2 ? 8'h20 : 8'h80);
            w = w | (m == 3 ? 8'h40 : 8'h00);
            apb(1, motor_protect_pkg::overload_control_idx, w);
            pwm_sync <= 1'b1;
            timer_sync <= 1'b1;
            @(posedge pclk);
            pwm_sync <= 1'b0;
            timer_sync <= 1'b0;
            apb(0, motor_protect_pkg::overload_control_idx, 0);
            chk({dis, rd[7:0]}, {6'h0, w & 8'h6f});
        end
        // A low clock enable freezes detection although the pin is low.
        ce <= 1'b0;
        o_req <= 1'b1;
        wt(80);
        chk({pready, counter_stop}, 0);
        o_req <= 1'b0;
        wt(4);
        ce <= 1'b1;
        wt(4);
        chk(irq, 0);
        apb(1, motor_protect_pkg::irq_mask_idx, 8'h03);
        chk(irq, 1);
        apb(0, motor_protect_pkg::irq_status_idx, 0);
        chk(rd, 3);
        apb(1, motor_protect_pkg::irq_status_idx, 8'h03);
        chk(irq, 0);
        apb(0, 14'h0001, 0);
        chk(er, 1);
        close_out();
    end
endmodule : tb
`default_nettype wire
